//--- common/iommu_diag_consts.svh
// Purpose: Offsets, field positions, resets for the cache diagnostic block
// Assumes: 12-bit byte address on the register bus
// Notes:   Definitions only
`ifndef IOMMU_DIAG_CONSTS_SVH
`define IOMMU_DIAG_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_GRP_CTRL     12'h080
`define OFS_DIAG_CTRL    12'h0C0
`define OFS_DIAG_DATA0   12'h0C4
`define OFS_DIAG_DATA7   12'h0E0
`define OFS_DIAG_TAG     12'h0E4
`define OFS_DATA_INJ     12'h0E8
`define OFS_TAG_INJ      12'h0EC
`define OFS_ACC_CTRL     12'h100
`define OFS_IRQ_STATUS   12'h140
`define OFS_IRQ_CLEAR    12'h144
`define OFS_IRQ_ENABLE   12'h148
`define OFS_BLK_FLUSH    8'h00
`define OFS_BLK_STATUS   8'h04
`define OFS_BLK_GRP      8'h80
// ----------------------------------------
// Field positions and sizes
// ----------------------------------------
`define BIT_GO           31
`define BIT_DIR          30
`define BIT_DPAR         21
`define BIT_TPAR         20
`define SET_MSB          18
`define BIT_FLUSH_OK     18
`define BIT_STATUS_OK    17
`define BIT_RSV16        16
`define NUM_BLK          4
`define NUM_GRP          8
`define NUM_WORDS        8
`define ACC_MASK         32'h0007FFFF
`define GRP_MASK         32'hFFFFFFF3
// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define RST_WORD         32'h00000000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

//--- common/iommu_diag_pkg.sv
// Purpose: Types for the cache diagnostic block
// Assumes: Nothing
// Notes:   Constants live in iommu_diag_consts.svh
package iommu_diag_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic {ST_IDLE, ST_WAIT} diag_state_t;
endpackage : iommu_diag_pkg

//--- verilog/iommu_cache_diag.sv
// Purpose: Cache diagnostic access, parity injection, block write permits
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   Contract
// Contract
// - Go bit starts op, clears when done
// - Go with direction one reads set
// - Go with direction zero writes staging
// - Data RAM parity error sets flag
// - Tag RAM parity error sets flag
// - Set address change clears staging
// - Diagnostic registers need diagnostic enable
// - Eight data words from 0xC4
// - Protection vector stored bit reversed
// - Tag in 31:1, valid bit 0
// - Data inject bits XOR byte parity
// - Tag inject bits XOR byte parity
// - Bit 18 permits block flush writes
// - Bit 17 permits block status writes
// - Bits 7:0 permit group control writes; only block-window writes are checked, direct ones at 0x80 plus 4n are not
// - Group control n at 0x80 plus 4n
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "iommu_diag_consts.svh"
module iommu_cache_diag import iommu_diag_pkg::*; (
	input  wire logic         mclk,          // 50 MHz clock
	input  wire logic         rst_b,         // Async reset
	input  wire logic         ce,            // Clock enable
	input  wire logic         diag_en,       // Diagnostic enable bit
	input  wire logic [11:0]  awaddr,        // Write address
	input  wire logic         awvalid,       // Write address valid
	output logic              awready,       // Write address ready
	input  wire logic [31:0]  wdata,         // Write data
	input  wire logic [3:0]   wstrb,         // Byte enables
	input  wire logic         wvalid,        // Write data valid
	output logic              wready,        // Write data ready
	output logic [1:0]        bresp,         // Write response
	output logic              bvalid,        // Write response valid
	input  wire logic         bready,        // Write response ready
	input  wire logic [11:0]  araddr,        // Read address
	input  wire logic         arvalid,       // Read address valid
	output logic              arready,       // Read address ready
	output logic [31:0]       rdata,         // Read data
	output logic [1:0]        rresp,         // Read response
	output logic              rvalid,        // Read data valid
	input  wire logic         rready,        // Read data ready
	output logic              cache_req,     // Cache RAM request
	output logic              cache_we,      // Cache RAM write
	output logic [18:0]       cache_set,     // Cache set
	output logic [255:0]      cache_wdata,   // Line to write
	output logic [31:0]       cache_wdpar,   // Byte parity of line
	output logic [31:0]       cache_wtag,    // Tag to write
	output logic [3:0]        cache_wtpar,   // Byte parity of tag
	input  wire logic         cache_ack,     // Cache RAM done
	input  wire logic [255:0] cache_rdata,   // Line read
	input  wire logic [31:0]  cache_rdpar,   // Stored line parity
	input  wire logic [31:0]  cache_rtag,    // Tag read
	input  wire logic [3:0]   cache_rtpar,   // Stored tag parity
	input  wire logic         lkup_dpar_err, // Lookup data parity error
	input  wire logic         lkup_tpar_err, // Lookup tag parity error
	input  wire logic         fill_valid,    // Vector fill request
	output logic              fill_ready,    // Fill accepted
	input  wire logic [18:0]  fill_set,      // Fill set
	input  wire logic [127:0] fill_vec,      // Fetched vector
	input  wire logic [31:0]  fill_tag,      // Fill tag
	output logic [3:0]        flush_write_permit,  // Per block
	output logic [3:0]        status_write_permit, // Per block
	output logic [3:0]        flush_req,     // Flush write pulse
	output logic              status_wr,     // Status write pulse
	output logic [1:0]        status_blk,    // Block of status write
	output logic [31:0]       status_wdata,  // Status write data
	output logic [255:0]      grp_ctrl_flat, // Group control 0..7
	output logic              irq            // Interrupt level
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// One even parity bit per byte
	function automatic logic [31:0] byte_par(input logic [255:0] d);
		logic [31:0] p;
		p = '0;
		for (int i = 0; i < 32; i++) begin
			p[i] = ^d[8*i +: 8];
		end
		return p;
	endfunction : byte_par

	// Byte-lane merge of a write
	function automatic word_t merge(input word_t o, input word_t n, input logic [3:0] s);
		word_t r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// Even parity per byte of a tag word
	function automatic logic [3:0] tag_par(input word_t t);
		logic [3:0] p;
		p = '0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ^t[8*i +: 8];
		end
		return p;
	endfunction : tag_par

	// Bit order reversed, fetched bit 127 lands in bit 0
	function automatic logic [127:0] rev128(input logic [127:0] v);
		logic [127:0] r;
		r = '0;
		for (int i = 0; i < 128; i++) begin
			r[i] = v[127 - i];
		end
		return r;
	endfunction : rev128

	// ----------------------------------------
	// State
	// ----------------------------------------
	diag_state_t          state;
	logic                 dir;
	logic [18:0]          set_addr;
	logic                 dpar;
	logic                 tpar;
	word_t                stage [`NUM_WORDS];
	word_t                stage_tag;
	word_t                dinj;
	word_t                tinj;
	word_t                acc [`NUM_BLK];
	word_t                grp [`NUM_GRP];
	logic [3:0]           irq_st;
	logic [3:0]           irq_en;
	logic                 aw_held;
	logic                 w_held;
	logic [11:0]          aw_a;
	word_t                w_d;
	logic [3:0]           w_s;
	logic                 wr_fire;
	logic [11:0]          a;
	word_t                cur;
	word_t                nw;
	logic                 is_diag;
	logic                 mapped;
	logic                 go_wr;
	logic                 set_chg;
	logic                 rd_done;
	logic                 dp_ev;
	logic                 tp_ev;
	logic                 inhib;
	logic [1:0]           blk;
	logic [7:0]           boff;
	logic [255:0]         line;
	logic [3:0]           next_irq_ev;

	assign wr_fire = aw_held && w_held && !bvalid;
	assign a = aw_a;
	assign blk = a[9:8];
	assign boff = a[7:0];
	assign rd_done = (state == ST_WAIT) && cache_ack && !cache_we;
	assign dp_ev = lkup_dpar_err || (rd_done && (byte_par(cache_rdata) != cache_rdpar));
	assign tp_ev = lkup_tpar_err || (rd_done && (tag_par(cache_rtag) != cache_rtpar));

	// Decode of the write in hand and the value it leaves
	always_comb begin
		is_diag = (a >= `OFS_DIAG_CTRL) && (a <= `OFS_DIAG_TAG);
		mapped = 1'b1;
		inhib = 1'b0;
		cur = `RST_WORD;
		if (a == `OFS_DIAG_CTRL) begin
			cur = {state == ST_WAIT, dir, 10'h000, 1'b0, set_addr};
		end else if (a >= `OFS_DIAG_DATA0 && a <= `OFS_DIAG_DATA7) begin
			cur = stage[3'(a[4:2] - 3'h1)];
		end else if (a == `OFS_DIAG_TAG) begin
			cur = stage_tag;
		end else if (a == `OFS_DATA_INJ) begin
			cur = dinj;
		end else if (a == `OFS_TAG_INJ) begin
			cur = tinj;
		end else if (a[11:4] == `OFS_ACC_CTRL >> 4) begin
			cur = acc[a[3:2]];
		end else if (a[11:5] == `OFS_GRP_CTRL >> 5) begin
			cur = grp[a[4:2]];
		end else if (a == `OFS_IRQ_ENABLE) begin
			cur = {28'h0, irq_en};
		end else if (a[11:10] == 2'h1 && boff == `OFS_BLK_FLUSH) begin
			inhib = !acc[blk][`BIT_FLUSH_OK];
		end else if (a[11:10] == 2'h1 && boff == `OFS_BLK_STATUS) begin
			inhib = !acc[blk][`BIT_STATUS_OK];
		end else if (a[11:10] == 2'h1 && boff[7:5] == `OFS_BLK_GRP >> 5) begin
			cur = grp[boff[4:2]];
			inhib = !acc[blk][boff[4:2]];
		end else if (a != `OFS_IRQ_CLEAR) begin
			mapped = 1'b0;
		end
		nw = merge(cur, w_d, w_s);
		go_wr = wr_fire && diag_en && a == `OFS_DIAG_CTRL && nw[`BIT_GO] && state == ST_IDLE;
		set_chg = wr_fire && diag_en && a == `OFS_DIAG_CTRL && nw[18:0] != set_addr;
	end

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	// Hold address and data apart, answer once both are in
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			aw_a <= 12'h000;
			w_d <= `RST_WORD;
			w_s <= 4'h0;
		end else if (ce) begin
			awready <= !aw_held && !awready && awvalid;
			wready <= !w_held && !wready && wvalid;
			if (awready && awvalid) begin
				aw_held <= 1'b1;
				aw_a <= awaddr;
			end
			if (wready && wvalid) begin
				w_held <= 1'b1;
				w_d <= wdata;
				w_s <= wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (!mapped || (is_diag && !diag_en)) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Diagnostic control and cache port
	// ----------------------------------------
	// Control fields, go sequencing and vector fill
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			dir <= 1'b0;
			set_addr <= 19'h00000;
			cache_req <= 1'b0;
			cache_we <= 1'b0;
			cache_set <= 19'h00000;
			cache_wdata <= 256'h0;
			cache_wdpar <= `RST_WORD;
			cache_wtag <= `RST_WORD;
			cache_wtpar <= 4'h0;
			fill_ready <= 1'b0;
		end else if (ce) begin
			fill_ready <= 1'b0;
			if (wr_fire && diag_en && a == `OFS_DIAG_CTRL && state == ST_IDLE) begin
				dir <= nw[`BIT_DIR];
				set_addr <= nw[`SET_MSB:0];
			end
			case (state)
				ST_IDLE: begin
					if (go_wr) begin
						state <= ST_WAIT;
						cache_req <= 1'b1;
						cache_we <= !nw[`BIT_DIR];
						cache_set <= nw[`SET_MSB:0];
						cache_wdata <= line;
						cache_wdpar <= byte_par(line) ^ dinj;
						cache_wtag <= stage_tag;
						cache_wtpar <= tag_par(stage_tag) ^ tinj[3:0];
					end else if (fill_valid && !fill_ready) begin
						state <= ST_WAIT;
						fill_ready <= 1'b1;
						cache_req <= 1'b1;
						cache_we <= 1'b1;
						cache_set <= fill_set;
						cache_wdata <= {128'h0, rev128(fill_vec)};
						cache_wdpar <= byte_par({128'h0, rev128(fill_vec)}) ^ dinj;
						cache_wtag <= fill_tag;
						cache_wtpar <= tag_par(fill_tag) ^ tinj[3:0];
					end
				end
				ST_WAIT: begin
					if (cache_ack) begin
						state <= ST_IDLE;
						cache_req <= 1'b0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Staging words packed into one line
	always_comb begin
		for (int i = 0; i < `NUM_WORDS; i++) begin
			line[32*i +: 32] = stage[i];
		end
	end

	// Staging data and tag: RAM read wins, then set change, then software
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < `NUM_WORDS; i++) begin
				stage[i] <= `RST_WORD;
			end
			stage_tag <= `RST_WORD;
		end else if (ce) begin
			if (rd_done) begin
				for (int i = 0; i < `NUM_WORDS; i++) begin
					stage[i] <= cache_rdata[32*i +: 32];
				end
				stage_tag <= cache_rtag;
			end else if (set_chg) begin
				for (int i = 0; i < `NUM_WORDS; i++) begin
					stage[i] <= `RST_WORD;
				end
				stage_tag <= `RST_WORD;
			end else if (wr_fire && diag_en && state == ST_IDLE) begin
				if (a >= `OFS_DIAG_DATA0 && a <= `OFS_DIAG_DATA7) begin
					stage[3'(a[4:2] - 3'h1)] <= nw;
				end
				if (a == `OFS_DIAG_TAG) begin
					stage_tag <= nw;
				end
			end
		end
	end

	// Parity flags: new go clears, any error sets, set wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dpar <= 1'b0;
			tpar <= 1'b0;
		end else if (ce) begin
			dpar <= dp_ev || (dpar && !go_wr);
			tpar <= tp_ev || (tpar && !go_wr);
		end
	end

	// ----------------------------------------
	// Injection, permits, group control
	// ----------------------------------------
	// Software registers behind the permit checks
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dinj <= `RST_WORD;
			tinj <= `RST_WORD;
			for (int i = 0; i < `NUM_BLK; i++) begin
				acc[i] <= `RST_WORD;
			end
			for (int i = 0; i < `NUM_GRP; i++) begin
				grp[i] <= `RST_WORD;
			end
		end else if (ce && wr_fire && !inhib) begin
			if (a == `OFS_DATA_INJ) begin
				dinj <= nw;
			end
			if (a == `OFS_TAG_INJ) begin
				tinj <= nw;
			end
			if (a[11:4] == `OFS_ACC_CTRL >> 4) begin
				acc[a[3:2]] <= nw & `ACC_MASK;
			end
			if (a[11:5] == `OFS_GRP_CTRL >> 5) begin
				grp[a[4:2]] <= nw & `GRP_MASK;
			end
			if (a[11:10] == 2'h1 && boff[7:5] == `OFS_BLK_GRP >> 5) begin
				grp[boff[4:2]] <= nw & `GRP_MASK;
			end
		end
	end

	// Pulses toward flush logic and the status register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flush_req <= 4'h0;
			status_wr <= 1'b0;
			status_blk <= 2'h0;
			status_wdata <= `RST_WORD;
		end else if (ce) begin
			flush_req <= 4'h0;
			status_wr <= 1'b0;
			if (wr_fire && !inhib && a[11:10] == 2'h1 && boff == `OFS_BLK_FLUSH) begin
				flush_req[blk] <= 1'b1;
			end
			if (wr_fire && !inhib && a[11:10] == 2'h1 && boff == `OFS_BLK_STATUS) begin
				status_wr <= 1'b1;
				status_blk <= blk;
				status_wdata <= nw;
			end
		end
	end

	// Registered copies for the outside
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flush_write_permit <= 4'h0;
			status_write_permit <= 4'h0;
			grp_ctrl_flat <= 256'h0;
		end else if (ce) begin
			for (int i = 0; i < `NUM_BLK; i++) begin
				flush_write_permit[i] <= acc[i][`BIT_FLUSH_OK];
				status_write_permit[i] <= acc[i][`BIT_STATUS_OK];
			end
			for (int i = 0; i < `NUM_GRP; i++) begin
				grp_ctrl_flat[32*i +: 32] <= grp[i];
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign next_irq_ev = {inhib && wr_fire, tp_ev, dp_ev, (state == ST_WAIT) && cache_ack};

	// Sticky status, write-one clear, set wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st <= 4'h0;
			irq_en <= 4'h0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr_fire && a == `OFS_IRQ_ENABLE) begin
				irq_en <= nw[3:0];
			end
			if (wr_fire && a == `OFS_IRQ_CLEAR) begin
				irq_st <= next_irq_ev | (irq_st & ~(w_d[3:0] & {4{w_s[0]}}));
			end else begin
				irq_st <= next_irq_ev | irq_st;
			end
			irq <= |(irq_st & irq_en);
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	// One read at a time, answered the cycle after the address
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= `RST_WORD;
			rresp <= `RESP_OKAY;
		end else if (ce) begin
			arready <= !arready && !rvalid && arvalid;
			if (arready && arvalid) begin
				rvalid <= 1'b1;
				rresp <= `RESP_OKAY;
				rdata <= `RST_WORD;
				if (araddr >= `OFS_DIAG_CTRL && araddr <= `OFS_DIAG_TAG && !diag_en) begin
					rresp <= `RESP_SLVERR;
				end else if (araddr == `OFS_DIAG_CTRL) begin
					rdata <= {state == ST_WAIT, dir, 8'h00, dpar, tpar, 1'b0, set_addr};
				end else if (araddr >= `OFS_DIAG_DATA0 && araddr <= `OFS_DIAG_DATA7) begin
					rdata <= stage[3'(araddr[4:2] - 3'h1)];
				end else if (araddr == `OFS_DIAG_TAG) begin
					rdata <= stage_tag;
				end else if (araddr == `OFS_DATA_INJ) begin
					rdata <= dinj;
				end else if (araddr == `OFS_TAG_INJ) begin
					rdata <= tinj;
				end else if (araddr[11:4] == `OFS_ACC_CTRL >> 4) begin
					rdata <= acc[araddr[3:2]];
				end else if (araddr[11:5] == `OFS_GRP_CTRL >> 5) begin
					rdata <= grp[araddr[4:2]];
				end else if (araddr == `OFS_IRQ_STATUS) begin
					rdata <= {28'h0, irq_st};
				end else if (araddr == `OFS_IRQ_ENABLE) begin
					rdata <= {28'h0, irq_en};
				end else if (araddr != `OFS_IRQ_CLEAR) begin
					rresp <= `RESP_SLVERR;
				end
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b || !ce);

	chk_go_starts: assert property (go_wr |=> cache_req && state == ST_WAIT)
		else $error("go did not start a cache op");
	chk_go_clears: assert property (state == ST_WAIT && cache_ack |=> state == ST_IDLE)
		else $error("go bit not cleared after ack");
	chk_read_dir: assert property (go_wr && nw[`BIT_DIR] |=> !cache_we)
		else $error("read op issued as write");
	chk_write_line: assert property (go_wr && !nw[`BIT_DIR] |=> cache_we && cache_wdata == $past(line))
		else $error("write op lost staging data");
	chk_dpar_set: assert property (dp_ev |=> dpar)
		else $error("data parity flag missed");
	chk_tpar_set: assert property (tp_ev |=> tpar)
		else $error("tag parity flag missed");
	chk_set_clear: assert property (set_chg && !rd_done |=> stage_tag == `RST_WORD && stage[0] == `RST_WORD)
		else $error("staging kept after set change");
	chk_diag_gate: assert property (wr_fire && is_diag && !diag_en |=> bresp == `RESP_SLVERR && $stable(set_addr))
		else $error("diagnostic write passed while disabled");
	chk_inject_par: assert property (go_wr |=> cache_wdpar == (byte_par(cache_wdata) ^ dinj))
		else $error("data parity injection wrong");
	chk_flush_gate: assert property (flush_req[blk] && $past(wr_fire) |-> $past(acc[blk][`BIT_FLUSH_OK]))
		else $error("flush passed without permit");
	chk_inhib_okay: assert property (wr_fire && inhib |=> bresp == `RESP_OKAY && bvalid)
		else $error("inhibited write answered with error");
	cov_diag_read: cover property (go_wr && nw[`BIT_DIR] ##[1:20] rd_done);
	cov_diag_write: cover property (go_wr && !nw[`BIT_DIR]);
	cov_inhibit: cover property (wr_fire && inhib);
	cov_irq: cover property (irq);
endmodule : iommu_cache_diag
`default_nettype wire

//--- dv/iommu_cache_diag_and_access_ctrl_bench.sv
// Purpose: Self-checking bench for the cache diagnostic and access control block
// Assumes: Bench is the register bus master and plays the cache RAM side
// Notes:   Expected values come from a small register model held in the bench
`timescale 1ns/1ps
`default_nettype none
`include "iommu_diag_consts.svh"
module iommu_cache_diag_and_access_ctrl_bench import iommu_diag_pkg::*; ;
	localparam logic [1:0] OK = `RESP_OKAY;
	localparam logic [1:0] ER = `RESP_SLVERR;
	logic mclk, rst_b, ce, diag_en, awvalid, wvalid, bready, arvalid, rready, cache_ack;
	logic awready, wready, bvalid, arready, rvalid, cache_req, cache_we, fill_ready, irq;
	logic lkup_dpar_err, lkup_tpar_err, fill_valid, status_wr;
	logic [11:0]  awaddr, araddr;
	logic [31:0]  wdata, rdata, cache_wdpar, cache_wtag, cache_rdpar, cache_rtag;
	logic [31:0]  fill_tag, status_wdata;
	logic [3:0]   wstrb, cache_wtpar, cache_rtpar, flush_write_permit, status_write_permit;
	logic [3:0]   flush_req;
	logic [1:0]   bresp, rresp, status_blk;
	logic [18:0]  cache_set, fill_set, s;
	logic [255:0] cache_wdata, cache_rdata, grp_ctrl_flat, ln;
	logic [127:0] fill_vec, v, rv;
	word_t        di, ti, tg, acc, d, p, grp[8];
	int           n_errors, n_checks, cyc, k, i, st_cnt, fl_cnt[4];

	iommu_cache_diag dut (.mclk, .rst_b, .ce, .diag_en, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .cache_req, .cache_we, .cache_set, .cache_wdata,
		.cache_wdpar, .cache_wtag, .cache_wtpar, .cache_ack, .cache_rdata, .cache_rdpar,
		.cache_rtag, .cache_rtpar, .lkup_dpar_err, .lkup_tpar_err, .fill_valid, .fill_ready,
		.fill_set, .fill_vec, .fill_tag, .flush_write_permit, .status_write_permit,
		.flush_req, .status_wr, .status_blk, .status_wdata, .grp_ctrl_flat, .irq);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic word_t par(input logic [255:0] x);
		for (int b = 0; b < 32; b++) par[b] = ^x[8*b+:8];
	endfunction : par

	task automatic chk(input logic [255:0] g, input logic [255:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// Bus write; address and data are held until each is taken
	task automatic wr(input logic [11:0] a, input word_t x, input logic [1:0] er);
		logic ah, wh, bh;
		logic [1:0] r;
		int t;
		t = 0;
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge mclk);
			ah = awready;
			wh = wready;
			bh = bvalid;
			r = bresp;
			@(posedge mclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			t++;
		end while (!bh && t < 50);
		chk(bh, 1'b1);
		chk(r, er);
	endtask : wr

	// Bus read compared with the expected word and response
	task automatic rd(input logic [11:0] a, input word_t e, input logic [1:0] er);
		logic ah, rh;
		logic [1:0] r;
		word_t g;
		int t;
		t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge mclk);
			ah = arready;
			rh = rvalid;
			g = rdata;
			r = rresp;
			@(posedge mclk);
			if (ah) arvalid <= 1'b0;
			t++;
		end while (!rh && t < 50);
		chk(rh, 1'b1);
		chk(g, e);
		chk(r, er);
	endtask : rd

	// Waits until a level is seen high, ends mid-cycle
	task automatic waitfor(ref logic sig);
		int t;
		t = 0;
		do begin
			@(negedge mclk);
			t++;
		end while (sig !== 1'b1 && t < 50);
		chk(sig, 1'b1);
	endtask : waitfor

	task automatic ack;
		@(posedge mclk);
		cache_ack <= 1'b1;
		@(posedge mclk);
		cache_ack <= 1'b0;
	endtask : ack

	// ----------------------------------------
	// Clock, pulse counters and hang limit
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Counted mid-cycle so pulses never race the checks
	always @(negedge mclk) begin
		cyc++;
		for (int b = 0; b < 4; b++) if (flush_req[b]) fl_cnt[b]++;
		if (status_wr) st_cnt++;
		if (cyc == 6000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_b, awvalid, wvalid, arvalid, cache_ack, lkup_dpar_err, lkup_tpar_err} = '0;
		{fill_valid, awaddr, araddr, wdata, fill_set, fill_vec, fill_tag} = '0;
		{cache_rdata, cache_rdpar, cache_rtag, cache_rtpar} = '0;
		{ce, diag_en, bready, rready, wstrb} = 8'hFF;
		foreach (grp[j]) grp[j] = '0;
		d = $urandom(51);
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rd(`OFS_DATA_INJ, 0, OK);
		rd(`OFS_ACC_CTRL, 0, OK);
		di = $urandom;
		ti = $urandom;
		wr(`OFS_DATA_INJ, di, OK);
		wr(`OFS_TAG_INJ, ti, OK);
		rd(`OFS_TAG_INJ, ti, OK);
		// Staging words written into the cache
		s = 19'($urandom);
		wr(`OFS_DIAG_CTRL, 32'(s), OK);
		for (int n = 0; n < 8; n++) begin
			ln[32*n+:32] = $urandom;
			wr(`OFS_DIAG_DATA0 + 12'(4*n), ln[32*n+:32], OK);
		end
		tg = $urandom;
		p = par(256'(tg));
		wr(`OFS_DIAG_TAG, tg, OK);
		wr(`OFS_DIAG_CTRL, 32'h80000000 | 32'(s), OK);
		waitfor(cache_req);
		chk({cache_we, cache_set}, {1'b1, s});
		chk({cache_wdata, cache_wtag}, {ln, tg});
		chk(cache_wdpar, par(ln) ^ di);
		chk(cache_wtpar, p[3:0] ^ ti[3:0]);
		ack();
		rd(`OFS_DIAG_CTRL, 32'(s), OK);
		// Cache set read back, byte 5 parity corrupted
		for (int n = 0; n < 8; n++) ln[32*n+:32] = $urandom;
		cache_rdata <= ln;
		cache_rdpar <= par(ln) ^ 32'h20;
		cache_rtag <= tg;
		cache_rtpar <= p[3:0];
		wr(`OFS_DIAG_CTRL, 32'hC0000000 | 32'(s), OK);
		waitfor(cache_req);
		chk(cache_we, 1'b0);
		ack();
		for (int n = 0; n < 8; n++) rd(`OFS_DIAG_DATA0 + 12'(4*n), ln[32*n+:32], OK);
		rd(`OFS_DIAG_TAG, tg, OK);
		rd(`OFS_DIAG_CTRL, 32'h40200000 | 32'(s), OK);
		lkup_tpar_err <= 1'b1;
		@(posedge mclk);
		lkup_tpar_err <= 1'b0;
		rd(`OFS_DIAG_CTRL, 32'h40300000 | 32'(s), OK);
		wr(`OFS_DIAG_CTRL, 32'h40000000 | 32'(s ^ 19'h1), OK);
		rd(`OFS_DIAG_DATA0, 0, OK);
		diag_en <= 1'b0;
		rd(`OFS_DIAG_TAG, 0, ER);
		wr(`OFS_DIAG_DATA0, 1, ER);
		rd(12'h200, 0, ER);
		// Vector fill lands bit reversed in the low half of the line
		v = {$urandom, $urandom, $urandom, $urandom};
		for (int b = 0; b < 128; b++) rv[b] = v[127-b];
		fill_vec <= v;
		fill_valid <= 1'b1;
		waitfor(fill_ready);
		@(posedge mclk);
		fill_valid <= 1'b0;
		waitfor(cache_req);
		chk(cache_wdata, {128'h0, rv});
		ack();
		// Group control and per-block write permits
		i = $urandom % 8;
		d = $urandom;
		grp[i] = d & `GRP_MASK;
		wr(`OFS_GRP_CTRL + 12'(4*i), d, OK);
		@(negedge mclk);
		chk(grp_ctrl_flat[32*i+:32], grp[i]);
		wr(`OFS_IRQ_ENABLE, 32'h8, OK);
		wr(`OFS_IRQ_CLEAR, 32'hF, OK);
		for (int n = 0; n < 4; n++) begin
			acc = $urandom;
			if (n == 0) acc[18] = 1'b0;
			wr(`OFS_ACC_CTRL + 12'(4*n), acc, OK);
			acc &= `ACC_MASK;
			rd(`OFS_ACC_CTRL + 12'(4*n), acc, OK);
			chk({flush_write_permit[n], status_write_permit[n]}, acc[18:17]);
			k = fl_cnt[n];
			wr(12'h400 + 12'(256*n), $urandom, OK);
			chk(fl_cnt[n] - k, acc[18]);
			k = st_cnt;
			wr(12'h404 + 12'(256*n), $urandom, OK);
			chk(st_cnt - k, acc[17]);
			i = $urandom % 8;
			d = $urandom;
			if (acc[i]) grp[i] = d & `GRP_MASK;
			wr(12'h480 + 12'(256*n + 4*i), d, OK);
			@(negedge mclk);
			chk(grp_ctrl_flat[32*i+:32], grp[i]);
		end
		chk(irq, 1'b1);
		wr(`OFS_IRQ_CLEAR, 32'hF, OK);
		wr(`OFS_IRQ_ENABLE, 0, OK);
		wr(`OFS_ACC_CTRL, 0, OK);
		wr(12'h404, 1, OK);
		@(negedge mclk);
		chk(irq, 1'b0);
		@(posedge mclk);
		rd(`OFS_IRQ_STATUS, 32'h8, OK);
		print_verdict();
	end
endmodule : iommu_cache_diag_and_access_ctrl_bench
`default_nettype wire
